// >>> common/exec_pkg.sv
/*
  Shared definitions for the shift, rotate and string execution unit: register
  offsets, field positions, operation codes, segment codes, states and carriers.
  Assumes a 32-bit classic Wishbone register bus and a 16-bit operand port.
*/
package exec_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_COUNT   = 8'h0c;
  localparam logic [7:0] OFF_REPCNT  = 8'h10;
  localparam logic [7:0] OFF_SRCIDX  = 8'h14;
  localparam logic [7:0] OFF_DSTIDX  = 8'h18;
  localparam logic [7:0] OFF_ACC     = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // Control register fields.
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_WORD_BIT = 4;
  localparam int CTRL_CNT_BIT  = 5;
  localparam int CTRL_REP_LSB  = 6;
  localparam int CTRL_OVR_BIT  = 8;
  localparam int CTRL_SEG_LSB  = 9;
  localparam int CTRL_GO_BIT   = 31;

  // Flag register bit positions.
  localparam int FLG_CARRY  = 0;
  localparam int FLG_PARITY = 2;
  localparam int FLG_ZERO   = 6;
  localparam int FLG_SIGN   = 7;
  localparam int FLG_DIR    = 10;
  localparam int FLG_OVF    = 11;

  // Status register bit positions.
  localparam int STS_BUSY = 0;
  localparam int STS_SUSP = 1;

  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  localparam logic [7:0]  COUNT_ONE   = 8'h01;

  typedef enum logic [3:0] {
    OP_SAR   = 4'b0000,
    OP_ROL   = 4'b0001,
    OP_ROR   = 4'b0010,
    OP_RCL   = 4'b0011,
    OP_RCR   = 4'b0100,
    OP_MOVE  = 4'b1000,
    OP_CMP   = 4'b1001,
    OP_SCAN  = 4'b1010,
    OP_LOAD  = 4'b1011,
    OP_STORE = 4'b1100
  } op_t;

  typedef enum logic [1:0] {
    REP_NONE    = 2'b00,
    REP_EQUAL   = 2'b01,
    REP_UNEQUAL = 2'b10
  } rep_t;

  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_CODE  = 2'b01,
    SEG_STACK = 2'b10,
    SEG_DATA  = 2'b11
  } seg_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SHIFT  = 3'b001,
    ST_CHECK  = 3'b010,
    ST_RD_SRC = 3'b011,
    ST_RD_DST = 3'b100,
    ST_WR_DST = 3'b101,
    ST_UPDATE = 3'b110
  } state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        word;
    seg_t        seg;
    logic [15:0] off;
    logic [15:0] wdata;
  } mem_req_t;

endpackage

// >>> design/shift_rotate_string_exec.sv
/*
  Shift, rotate and repeated string execution unit with a Wishbone slave.
  Assumes a classic Wishbone master on wb_i and a bus interface unit that
  answers each mem_o request with a one-cycle mem_ack_i.
*/
`timescale 1ns/100ps
`default_nettype none

module shift_rotate_string_exec (
  input  wire logic              clock_i,        // 10 MHz clock
  input  wire logic              reset_i,        // Synchronous reset, active high
  input  wire exec_pkg::wb_req_t wb_i,           // Wishbone request
  output logic [31:0]            wb_dat_o,       // Wishbone read data
  output logic                   wb_ack_o,       // Wishbone acknowledge
  output exec_pkg::mem_req_t     mem_o,          // Element access request
  input  wire logic              mem_ack_i,      // Element access done
  input  wire logic [15:0]       mem_rdata_i,    // Element read data
  input  wire logic              intr_pending_i, // Interrupt waiting
  output logic                   busy_o,         // Operation in progress
  output logic                   suspended_o     // Repeat stopped for interrupt
);
  import exec_pkg::*;

  typedef struct packed {
    state_t      st;
    op_t         op;
    logic        word;
    rep_t        repeat_prefix;
    logic        ovr_en;
    seg_t        ovr_seg;
    logic [7:0]  cnt;
    logic        orig_msb;
    logic [15:0] operand;
    logic [15:0] flags;
    logic [7:0]  count_low;
    logic [15:0] rep_cnt;
    logic [15:0] src_idx;
    logic [15:0] dst_idx;
    logic [15:0] acc;
    logic [15:0] src_data;
    logic        suspended;
    logic        ack;
    logic [31:0] rdata;
    mem_req_t    mem;
  } exec_state_t;

  exec_state_t state_ff;
  exec_state_t nxt_state;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] width_mask(input logic [15:0] v, input logic w);
    return w ? v : {8'h00, v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational views of the current state.

  logic        wr_en;
  logic [31:0] ctrl_new;
  logic        top_bit;
  logic [15:0] rot_val;
  logic        rot_cf;
  logic [15:0] step;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [16:0] diff;
  logic [15:0] diff_r;
  logic        a_msb;
  logic        b_msb;
  logic        r_msb;
  logic        dir;
  logic [15:0] rd_data;
  logic        is_rep;
  logic [31:0] reg_view;
  logic [31:0] wr_word;

  always_comb begin
    wr_en    = wb_i.cyc && wb_i.stb && wb_i.we && !state_ff.ack;
    ctrl_new = merge(32'h0000_0000, wb_i.dat, wb_i.sel);
    dir      = state_ff.flags[FLG_DIR];
    is_rep   = (state_ff.repeat_prefix != REP_NONE);
    // One view serves both the read path and the byte-lane merge of a write.
    case (wb_i.adr)
      OFF_CTRL:    reg_view = {27'h0, state_ff.word, state_ff.op};
      OFF_OPERAND: reg_view = {16'h0000, state_ff.operand};
      OFF_FLAGS:   reg_view = {16'h0000, state_ff.flags};
      OFF_COUNT:   reg_view = {24'h000000, state_ff.count_low};
      OFF_REPCNT:  reg_view = {16'h0000, state_ff.rep_cnt};
      OFF_SRCIDX:  reg_view = {16'h0000, state_ff.src_idx};
      OFF_DSTIDX:  reg_view = {16'h0000, state_ff.dst_idx};
      OFF_ACC:     reg_view = {16'h0000, state_ff.acc};
      OFF_STATUS:  reg_view = {30'h0, state_ff.suspended, state_ff.st != ST_IDLE};
      default:     reg_view = 32'h0000_0000;
    endcase
    wr_word  = merge(reg_view, wb_i.dat, wb_i.sel);
    step     = state_ff.word ? STEP_WORD : STEP_BYTE;
    rd_data  = width_mask(mem_rdata_i, state_ff.word);
    top_bit  = state_ff.word ? state_ff.operand[15] : state_ff.operand[7];
    rot_val  = state_ff.operand;
    rot_cf   = state_ff.flags[FLG_CARRY];
    case (state_ff.op)
      OP_SAR: begin
        rot_val = state_ff.word ? {top_bit, state_ff.operand[15:1]}
                                : {8'h00, top_bit, state_ff.operand[7:1]};
        rot_cf  = state_ff.operand[0];
      end
      OP_ROL: begin
        rot_val = state_ff.word ? {state_ff.operand[14:0], top_bit}
                                : {8'h00, state_ff.operand[6:0], top_bit};
        rot_cf  = top_bit;
      end
      OP_ROR: begin
        rot_val = state_ff.word ? {state_ff.operand[0], state_ff.operand[15:1]}
                                : {8'h00, state_ff.operand[0], state_ff.operand[7:1]};
        rot_cf  = state_ff.operand[0];
      end
      OP_RCL: begin
        rot_val = state_ff.word
                  ? {state_ff.operand[14:0], state_ff.flags[FLG_CARRY]}
                  : {8'h00, state_ff.operand[6:0], state_ff.flags[FLG_CARRY]};
        rot_cf  = top_bit;
      end
      OP_RCR: begin
        rot_val = state_ff.word
                  ? {state_ff.flags[FLG_CARRY], state_ff.operand[15:1]}
                  : {8'h00, state_ff.flags[FLG_CARRY], state_ff.operand[7:1]};
        rot_cf  = state_ff.operand[0];
      end
      default: begin
        rot_val = state_ff.operand;
        rot_cf  = state_ff.flags[FLG_CARRY];
      end
    endcase
    cmp_a  = width_mask((state_ff.op == OP_CMP) ? state_ff.src_data : state_ff.acc,
                        state_ff.word);
    cmp_b  = rd_data;
    diff   = {1'b0, cmp_a} - {1'b0, cmp_b};
    diff_r = width_mask(diff[15:0], state_ff.word);
    a_msb  = state_ff.word ? cmp_a[15] : cmp_a[7];
    b_msb  = state_ff.word ? cmp_b[15] : cmp_b[7];
    r_msb  = state_ff.word ? diff_r[15] : diff_r[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ack = wb_i.cyc && wb_i.stb && !state_ff.ack;
    nxt_state.rdata = reg_view;
    if (state_ff.mem.req && mem_ack_i) begin
      nxt_state.mem.req = 1'b0;
    end
    case (state_ff.st)
      ST_IDLE: begin
        if (wr_en) begin
          case (wb_i.adr)
            OFF_OPERAND: nxt_state.operand = wr_word[15:0];
            OFF_FLAGS:   nxt_state.flags = wr_word[15:0];
            OFF_COUNT:   nxt_state.count_low = wr_word[7:0];
            OFF_REPCNT:  nxt_state.rep_cnt = wr_word[15:0];
            OFF_SRCIDX:  nxt_state.src_idx = wr_word[15:0];
            OFF_DSTIDX:  nxt_state.dst_idx = wr_word[15:0];
            OFF_ACC:     nxt_state.acc = wr_word[15:0];
            OFF_CTRL: begin
              if (ctrl_new[CTRL_GO_BIT]) begin
                nxt_state.op        = op_t'(ctrl_new[CTRL_OP_LSB +: 4]);
                nxt_state.word      = ctrl_new[CTRL_WORD_BIT];
                nxt_state.repeat_prefix       = rep_t'(ctrl_new[CTRL_REP_LSB +: 2]);
                nxt_state.ovr_en    = ctrl_new[CTRL_OVR_BIT];
                nxt_state.ovr_seg   = seg_t'(ctrl_new[CTRL_SEG_LSB +: 2]);
                nxt_state.suspended = 1'b0;
                if (ctrl_new[CTRL_OP_LSB + 3]) begin
                  nxt_state.st = ST_CHECK;
                end else begin
                  nxt_state.cnt = ctrl_new[CTRL_CNT_BIT] ? state_ff.count_low
                                                         : COUNT_ONE;
                  nxt_state.orig_msb = ctrl_new[CTRL_WORD_BIT] ? state_ff.operand[15]
                                                               : state_ff.operand[7];
                  if ((ctrl_new[CTRL_CNT_BIT] ? state_ff.count_low : COUNT_ONE) != 8'h00) begin
                    nxt_state.st = ST_SHIFT;
                  end
                end
              end
            end
            default: ;
          endcase
        end
      end
      ST_SHIFT: begin
        nxt_state.operand          = rot_val;
        nxt_state.flags[FLG_CARRY] = rot_cf;
        nxt_state.cnt              = state_ff.cnt - 8'h01;
        if (state_ff.cnt == 8'h01) begin
          nxt_state.st = ST_IDLE;
          // Sign change against the original; for multibit counts this is just a value.
          nxt_state.flags[FLG_OVF] = (state_ff.word ? rot_val[15] : rot_val[7]) ^
                                     state_ff.orig_msb;
          if (state_ff.op == OP_SAR) begin
            nxt_state.flags[FLG_ZERO]   = (rot_val == 16'h0000);
            nxt_state.flags[FLG_SIGN]   = state_ff.word ? rot_val[15] : rot_val[7];
            nxt_state.flags[FLG_PARITY] = ~^rot_val[7:0];
          end
        end
      end
      ST_CHECK: begin
        if (is_rep && state_ff.rep_cnt == 16'h0000) begin
          nxt_state.st = ST_IDLE;
        end else if (is_rep && intr_pending_i) begin
          nxt_state.st        = ST_IDLE;
          nxt_state.suspended = 1'b1;
        end else begin
          nxt_state.mem.req   = 1'b1;
          nxt_state.mem.word  = state_ff.word;
          nxt_state.mem.wdata = width_mask(state_ff.acc, state_ff.word);
          case (state_ff.op)
            OP_SCAN: begin
              nxt_state.st      = ST_RD_DST;
              nxt_state.mem.we  = 1'b0;
              nxt_state.mem.seg = SEG_EXTRA;
              nxt_state.mem.off = state_ff.dst_idx;
            end
            OP_STORE: begin
              nxt_state.st      = ST_WR_DST;
              nxt_state.mem.we  = 1'b1;
              nxt_state.mem.seg = SEG_EXTRA;
              nxt_state.mem.off = state_ff.dst_idx;
            end
            default: begin
              nxt_state.st      = ST_RD_SRC;
              nxt_state.mem.we  = 1'b0;
              nxt_state.mem.seg = state_ff.ovr_en ? state_ff.ovr_seg : SEG_DATA;
              nxt_state.mem.off = state_ff.src_idx;
            end
          endcase
        end
      end
      ST_RD_SRC: begin
        if (mem_ack_i) begin
          nxt_state.src_data = rd_data;
          case (state_ff.op)
            OP_LOAD: begin
              nxt_state.acc = state_ff.word ? rd_data : {state_ff.acc[15:8], rd_data[7:0]};
              nxt_state.st  = ST_UPDATE;
            end
            OP_MOVE: begin
              nxt_state.st        = ST_WR_DST;
              nxt_state.mem.req   = 1'b1;
              nxt_state.mem.we    = 1'b1;
              nxt_state.mem.seg   = SEG_EXTRA;
              nxt_state.mem.off   = state_ff.dst_idx;
              nxt_state.mem.wdata = rd_data;
            end
            default: begin
              nxt_state.st      = ST_RD_DST;
              nxt_state.mem.req = 1'b1;
              nxt_state.mem.we  = 1'b0;
              nxt_state.mem.seg = SEG_EXTRA;
              nxt_state.mem.off = state_ff.dst_idx;
            end
          endcase
        end
      end
      ST_RD_DST: begin
        if (mem_ack_i) begin
          nxt_state.flags[FLG_CARRY]  = diff[16];
          nxt_state.flags[FLG_ZERO]   = (diff_r == 16'h0000);
          nxt_state.flags[FLG_SIGN]   = r_msb;
          nxt_state.flags[FLG_PARITY] = ~^diff_r[7:0];
          nxt_state.flags[FLG_OVF]    = (a_msb ^ b_msb) & (a_msb ^ r_msb);
          nxt_state.st                = ST_UPDATE;
        end
      end
      ST_WR_DST: begin
        if (mem_ack_i) begin
          nxt_state.st = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        if (state_ff.op != OP_SCAN && state_ff.op != OP_STORE) begin
          nxt_state.src_idx = dir ? state_ff.src_idx - step : state_ff.src_idx + step;
        end
        if (state_ff.op != OP_LOAD) begin
          nxt_state.dst_idx = dir ? state_ff.dst_idx - step : state_ff.dst_idx + step;
        end
        if (is_rep) begin
          nxt_state.rep_cnt = state_ff.rep_cnt - 16'h0001;
        end
        if (!is_rep) begin
          nxt_state.st = ST_IDLE;
        end else if ((state_ff.op == OP_CMP || state_ff.op == OP_SCAN) &&
                     ((state_ff.repeat_prefix == REP_EQUAL && !state_ff.flags[FLG_ZERO]) ||
                      (state_ff.repeat_prefix == REP_UNEQUAL && state_ff.flags[FLG_ZERO]))) begin
          nxt_state.st = ST_IDLE;
        end else begin
          nxt_state.st = ST_CHECK;
        end
      end
      default: nxt_state.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff       <= '0;
      state_ff.flags <= FLAGS_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_dat_o    = state_ff.rdata;
  assign wb_ack_o    = state_ff.ack;
  assign mem_o       = state_ff.mem;
  assign busy_o      = (state_ff.st != ST_IDLE);
  assign suspended_o = state_ff.suspended;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_SAR_SIGN: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_SHIFT && state_ff.op == OP_SAR && state_ff.word)
    |=> state_ff.operand[15] == $past(state_ff.operand[15]))
    else $error("Arithmetic shift lost the sign bit.");

  AST_ROT_FLAGS_KEPT: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_SHIFT && state_ff.op != OP_SAR)
    |=> (state_ff.flags[FLG_ZERO] == $past(state_ff.flags[FLG_ZERO])) &&
        (state_ff.flags[FLG_SIGN] == $past(state_ff.flags[FLG_SIGN])))
    else $error("Rotate changed a flag other than carry or overflow.");

  AST_ROL_CARRY: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_SHIFT && state_ff.op == OP_ROL && state_ff.word)
    |=> state_ff.flags[FLG_CARRY] == state_ff.operand[0])
    else $error("Rotate left carry differs from the wrapped bit.");

  AST_RCR_IN: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_SHIFT && state_ff.op == OP_RCR && state_ff.word)
    |=> state_ff.operand[15] == $past(state_ff.flags[FLG_CARRY]) &&
        state_ff.flags[FLG_CARRY] == $past(state_ff.operand[0]))
    else $error("Rotate right through carry moved the wrong bits.");

  AST_ZERO_SKIP: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_CHECK && is_rep && state_ff.rep_cnt == 16'h0000)
    |=> state_ff.st == ST_IDLE && !state_ff.mem.req)
    else $error("Zero repetition count still processed an element.");

  AST_DEST_SEG: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.mem.req && state_ff.st inside {ST_RD_DST, ST_WR_DST})
    |-> state_ff.mem.seg == SEG_EXTRA)
    else $error("Destination access outside the extra segment.");

  AST_INDEX_STEP: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_UPDATE && state_ff.op == OP_STORE)
    |=> state_ff.dst_idx == ($past(state_ff.flags[FLG_DIR])
        ? $past(state_ff.dst_idx) - $past(step) : $past(state_ff.dst_idx) + $past(step)))
    else $error("Destination index moved the wrong way or amount.");

  AST_COUNT_DEC: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_UPDATE && is_rep)
    |=> state_ff.rep_cnt == $past(state_ff.rep_cnt) - 16'h0001)
    else $error("Repetition counter did not drop by one.");

  AST_INTR_SUSPEND: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_ff.st == ST_CHECK && is_rep && state_ff.rep_cnt != 16'h0000 && intr_pending_i)
    |=> suspended_o && !busy_o && !state_ff.mem.req)
    else $error("Pending interrupt was not taken between elements.");

endmodule

`default_nettype wire

// >>> testbench/bus_unit_model.sv
/*
  Bus interface unit model answering element requests with varying stalls.
  Assumes the unit holds req until the cycle after the one-cycle ack.
*/
`timescale 1ns/100ps
`default_nettype none
module bus_unit_model (
  input  wire logic               clock_i,     // Clock
  input  wire logic               reset_i,     // Synchronous reset
  input  wire exec_pkg::mem_req_t mem_i,       // Element request
  output logic                    mem_ack_o,   // Access done
  output logic [15:0]             mem_rdata_o  // Read data
);
  import exec_pkg::*;
  logic [1:0]  wait_ff;
  logic [1:0]  delay_ff;
  logic [15:0] noise_ff;
  // Outside the ack cycle the data lines carry a pattern that changes every cycle.
  assign mem_rdata_o = mem_ack_o ? (mem_i.off ^ 16'h5a5a) : noise_ff;
  always_ff @(posedge clock_i) begin
    noise_ff <= reset_i ? 16'h0000 : noise_ff + 16'h3c5b;
    if (reset_i) begin
      mem_ack_o <= 1'b0;
      wait_ff   <= 2'h0;
      delay_ff  <= 2'h0;
    end else if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
    end else if (mem_i.req) begin
      if (wait_ff == delay_ff) begin
        mem_ack_o <= 1'b1;
        wait_ff   <= 2'h0;
        delay_ff  <= (delay_ff == 2'h2) ? 2'h0 : delay_ff + 2'h1;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_shift_rotate_string_exec.sv
/*
  Self-checking bench for the shift, rotate and string unit.
  Assumes the bus unit model answers element requests.
*/
`timescale 1ns/100ps
`default_nettype none
module test_shift_rotate_string_exec;
  import exec_pkg::*;
  logic clock_i = 0, reset_i = 1, mem_ack, intr = 0, busy, susp;
  wb_req_t wb_req = '0;
  mem_req_t mem_req;
  logic [31:0] wb_dat, v;
  logic wb_ack;
  logic [15:0] mem_rdata;
  logic [31:0] log_q [$];
  int errors = 0, tests_run = 0;
  always #50 clock_i = ~clock_i;
  shift_rotate_string_exec dut (.clock_i(clock_i), .reset_i(reset_i), .wb_i(wb_req),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .mem_o(mem_req), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .intr_pending_i(intr), .busy_o(busy), .suspended_o(susp));
  bus_unit_model biu (.clock_i(clock_i), .reset_i(reset_i), .mem_i(mem_req),
    .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
  always @(posedge clock_i)
    if (mem_req.req && mem_ack)
      log_q.push_back({mem_req.we ? mem_req.wdata[12:0] : 13'h0, mem_req.we, mem_req.seg,
                       mem_req.off});
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin @(posedge clock_i); end while (wb_ack !== 1'b1);
    v = wb_dat;
    wb_req <= '0;
    @(posedge clock_i);
  endtask
  task automatic wait_idle();
    while (busy !== 1'b0) begin @(posedge clock_i); end
  endtask
  task automatic go(input logic [31:0] c);
    bus(1, OFF_CTRL, c);
    wait_idle();
  endtask
  function automatic logic [31:0] ctrl(input logic [3:0] op, input logic w, input logic cs,
                                       input logic [1:0] repeat_prefix, input logic ov, input logic [1:0] sg);
    return {1'b1, 20'h0, sg, ov, repeat_prefix, cs, w, op};
  endfunction
  task automatic acc(input logic we, input logic [1:0] sg, input logic [15:0] off,
                     input logic [12:0] wd);
    check(log_q.size() ? log_q.pop_front() : 32'hx, {wd, we, sg, off});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Columns: op, word, count select, count, operand, flags in, result, flags, mask.
  logic [15:0] tbl [8][9] = '{
    '{0, 0, 0, 0, 16'h00fb, 16'h0000, 16'h00fd, 16'h0001, 16'h0801},
    '{0, 1, 1, 3, 16'h8005, 16'h0000, 16'hf000, 16'h0001, 16'h0001},
    '{1, 0, 0, 0, 16'h0081, 16'h0044, 16'h0003, 16'h0845, 16'h0fff},
    '{2, 1, 1, 1, 16'h0001, 16'h0044, 16'h8000, 16'h0845, 16'h0fff},
    '{3, 0, 0, 0, 16'h0080, 16'h0044, 16'h0000, 16'h0845, 16'h0fff},
    '{4, 0, 1, 1, 16'h0001, 16'h0045, 16'h0080, 16'h0845, 16'h0fff},
    '{1, 1, 1, 4, 16'h1234, 16'h0044, 16'h2341, 16'h0045, 16'h07ff},
    '{4, 1, 1, 2, 16'h0003, 16'h0045, 16'hc000, 16'h0045, 16'h07ff}};
  task automatic shift_rotate_table();
    for (int i = 0; i < 8; i++) begin
      bus(1, OFF_OPERAND, {16'h0, tbl[i][4]});
      bus(1, OFF_FLAGS, {16'h0, tbl[i][5]});
      bus(1, OFF_COUNT, {16'h0, tbl[i][3]});
      go(ctrl(tbl[i][0][3:0], tbl[i][1][0], tbl[i][2][0], REP_NONE, 1'b0, SEG_EXTRA));
      bus(0, OFF_OPERAND, 0);
      check(v, {16'h0, tbl[i][6]});
      bus(0, OFF_FLAGS, 0);
      check(v & {16'h0, tbl[i][8]}, {16'h0, tbl[i][7]});
    end
  endtask
  task automatic store_repeat_then_zero();
    bus(1, OFF_ACC, 32'hbeef);
    bus(1, OFF_DSTIDX, 32'h0100);
    bus(1, OFF_REPCNT, 32'h3);
    bus(1, OFF_FLAGS, 32'h1 << FLG_DIR);
    go(ctrl(OP_STORE, 1, 0, REP_EQUAL, 0, SEG_EXTRA));
    for (int k = 0; k < 3; k++) acc(1, SEG_EXTRA, 16'h0100 - 16'(2 * k), 13'h1eef);
    bus(0, OFF_REPCNT, 0);
    check(v, 0);
    bus(1, OFF_REPCNT, 0);
    go(ctrl(OP_STORE, 1, 0, REP_EQUAL, 0, SEG_EXTRA));
    check(32'(log_q.size()), 0);
    bus(0, OFF_DSTIDX, 0);
    check(v, 32'h00fa);
  endtask
  task automatic move_interrupt_resume();
    bus(1, OFF_SRCIDX, 32'h10);
    bus(1, OFF_DSTIDX, 32'h20);
    bus(1, OFF_REPCNT, 32'h2);
    bus(1, OFF_FLAGS, 0);
    bus(1, OFF_CTRL, ctrl(OP_MOVE, 0, 0, REP_EQUAL, 1, SEG_STACK));
    check({31'h0, busy}, 1);
    while (log_q.size() == 0) begin @(posedge clock_i); end
    intr <= 1'b1;
    wait_idle();
    check({31'h0, susp}, 1);
    bus(0, OFF_STATUS, 0);
    check(v, 32'h2);
    bus(0, OFF_REPCNT, 0);
    check(v, 1);
    intr <= 1'b0;
    go(ctrl(OP_MOVE, 0, 0, REP_EQUAL, 1, SEG_STACK));
    for (int k = 0; k < 2; k++) begin
      acc(0, SEG_STACK, 16'(16'h10 + k), 0);
      acc(1, SEG_EXTRA, 16'(16'h20 + k), 13'(16'h10 + k) ^ 13'h005a);
    end
  endtask
  // The bus unit returns each element as its offset xor 5a5a.
  task automatic scan_and_compare();
    bus(1, OFF_FLAGS, 0);
    bus(1, OFF_ACC, 32'h5a68);
    bus(1, OFF_DSTIDX, 32'h30);
    bus(1, OFF_REPCNT, 32'h5);
    go(ctrl(OP_SCAN, 1, 0, REP_UNEQUAL, 0, SEG_EXTRA));
    acc(0, SEG_EXTRA, 16'h0030, 0);
    acc(0, SEG_EXTRA, 16'h0032, 0);
    check(32'(log_q.size()), 0);
    bus(0, OFF_REPCNT, 0);
    check(v, 3);
    bus(0, OFF_FLAGS, 0);
    check(v, 32'h0044);
    bus(1, OFF_SRCIDX, 32'h10);
    bus(1, OFF_DSTIDX, 32'h20);
    go(ctrl(OP_CMP, 1, 0, REP_EQUAL, 0, SEG_EXTRA));
    acc(0, SEG_DATA, 16'h0010, 0);
    acc(0, SEG_EXTRA, 16'h0020, 0);
    check(32'(log_q.size()), 0);
    bus(0, OFF_REPCNT, 0);
    check(v, 2);
    bus(0, OFF_FLAGS, 0);
    check(v, 32'h0081);
    bus(0, OFF_SRCIDX, 0);
    check(v, 32'h12);
  endtask
  task automatic load_byte_and_unmapped();
    bus(1, OFF_ACC, 32'h1200);
    bus(1, OFF_SRCIDX, 32'h40);
    go(ctrl(OP_LOAD, 0, 0, REP_NONE, 0, SEG_EXTRA));
    acc(0, SEG_DATA, 16'h0040, 0);
    bus(0, OFF_ACC, 0);
    check(v, 32'h121a);
    bus(0, OFF_SRCIDX, 0);
    check(v, 32'h41);
    bus(0, 8'h24, 0);
    check(v, 0);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    shift_rotate_table();
    store_repeat_then_zero();
    move_interrupt_resume();
    scan_and_compare();
    load_byte_and_unmapped();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
